// >>> fifo_timing_mode_select_bench.sv
// self-checking bench for the timing mode selector
`timescale 1ns/1ns
module fifo_timing_mode_select_bench;
	import fts_pkg::*;
	localparam logic [17:0] BASE = 18'h0A5C3;
	logic        sys_clk, arst_n, masterResetN, doWrite, doRead, wrEnN, rdEnN;
	fts_cfg_t    modePins;
	logic [17:0] wrData, rdData;
	fts_flags_t  flags;
	fts_mode_t   fallThroughMode;
	int          num_errors, compares, sent, first;

	// ================================================================
	// design and far end
	fts_top #(.WIDTH(18), .DEPTH(8)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
		.masterResetN(masterResetN), .modePins(modePins), .wrEnN(wrEnN), .wrData(wrData),
		.rdEnN(rdEnN), .rdData(rdData), .flags(flags), .fallThroughMode(fallThroughMode));
	fts_far_end #(.WIDTH(18), .BASE(BASE)) far (.sys_clk(sys_clk), .arst_n(arst_n),
		.doWrite(doWrite), .doRead(doRead), .wrEnN(wrEnN), .wrData(wrData), .rdEnN(rdEnN));

	// ================================================================
	// helpers
	task step(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask
	function automatic logic [17:0] word(input int n);
		return BASE + 18'(n);
	endfunction
	// mode pins held through master reset, scrambled afterwards
	task mreset(input fts_cfg_t pins);
		step(1);
		masterResetN <= 1'b0;
		modePins <= pins;
		step(2);
		masterResetN <= 1'b1;
		step(1);
		modePins <= ~pins;
	endtask
	task writeN(input int n);
		step(1);
		doWrite <= 1'b1;
		step(n);
		doWrite <= 1'b0;
		sent += n;
	endtask

	// ================================================================
	// scenarios
	task testStdOne;
		mreset(3'h0);
		step(1);
		doRead <= 1'b1;
		step(1);
		doRead <= 1'b0;
		#1 chk(rdData === 18'h00000 && flags.emptyIndicatorN === 1'b0, "read on empty");
		chk(fallThroughMode === FTS_STD, "mode not standard");
		first = sent;
		writeN(1);
		#1 chk(flags.emptyIndicatorN === 1'b1, "empty after write");
		step(3);
		#1 chk(rdData === 18'h00000, "word shown unread");
		step(1);
		doRead <= 1'b1;
		step(1);
		doRead <= 1'b0;
		#1 chk(rdData === word(first), "read data");
		chk(flags.emptyIndicatorN === 1'b0, "empty after last read");
	endtask
	task testStdFill;
		mreset(3'h0);
		first = sent;
		writeN(10);
		#1 chk(flags.fullIndicatorN === 1'b0 && flags.inputReadyN === 1'b1, "not full");
		step(1);
		doRead <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			step(1);
			if (i == 8) doRead <= 1'b0;
			#1 chk(rdData === word(first + ((i < 8) ? i : 7)), "drain order");
		end
		chk(flags.emptyIndicatorN === 1'b0, "not empty");
	endtask
	task testFwftOne;
		mreset(3'h2);
		#1 chk(fallThroughMode === FTS_FALL_THROUGH_MODE, "mode not fall-through");
		first = sent;
		writeN(1);
		step(2);
		#1 chk(rdData === 18'h00000, "fell through early");
		step(1);
		#1 chk(rdData === word(first) && flags.outputReadyN === 1'b0, "no fall");
		step(1);
		doRead <= 1'b1;
		step(2);
		doRead <= 1'b0;
		#1 chk(flags.outputReadyN === 1'b1, "ready after last read");
		chk(rdData === word(first), "read on empty changed output");
	endtask
	task testFwftFill;
		mreset(3'h2);
		first = sent;
		writeN(10);
		step(4);
		#1 chk(flags.inputReadyN === 1'b1 && flags.fullIndicatorN === 1'b0, "cap");
		chk(rdData === word(first), "first word");
		step(1);
		doRead <= 1'b1;
		for (int i = 1; i < 10; i++) begin
			step(1);
			if (i == 9) doRead <= 1'b0;
			#1 if (i < 9) chk(rdData === word(first + i), "fall_through_mode order");
		end
		step(1);
		#1 chk(flags.outputReadyN === 1'b1, "ready when drained");
		chk(fallThroughMode === FTS_FALL_THROUGH_MODE, "mode followed pins after reset");
	endtask

	// ================================================================
	// verdict
	task final_report;
		if (num_errors == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// clock at 50 ns
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// watchdog
	initial begin
		repeat (2000) @(posedge sys_clk);
		num_errors++;
		final_report;
	end
	// main sequence
	initial begin
		arst_n = 1'b0;
		masterResetN = 1'b0;
		modePins = 3'h0;
		doWrite = 1'b0;
		doRead = 1'b0;
		step(6);
		arst_n <= 1'b1;
		#1 chk(flags === 4'h6 && rdData === 18'h00000, "reset state");
		testStdOne;
		testStdFill;
		testFwftOne;
		testFwftFill;
		final_report;
	end
endmodule

// >>> fts_defines.svh
// constants for the fall-through timing mode selector
// ====================================================================
// Behaviour
// R01: mode pins are sampled during master reset; outside holds them steady throughout.
// R02: standard mode keeps a freshly written word stored until an explicit read.
// R03: read is low read enable plus rising clock; moves next word to outputs.
// R04: fall-through mode presents first word after three clock edges unrequested.
// R05: fall-through first word needs no read enable; later words need reads.
// R06: standard empty indicator rises after first write, falls after last read.
// R07: fall-through output-ready falls after first write, rises after last read.
// R08: fall-through holds depth plus one words; input-ready rises only then.
// R09: read enable ignored while empty; data and pointers unchanged.
// R10: latched mode stays fixed until next master reset.
`ifndef FTS_DEFINES_SVH
`define FTS_DEFINES_SVH

// ====================================================================
// sizes and timing
`define FTS_DATA_WIDTH  18
`define FTS_MEM_DEPTH   8
`define FTS_FALL_EDGES  3

// ====================================================================
// mode pin pattern {firstLoad, readExp, writeExp} that picks fall-through
`define FTS_FALL_THROUGH_MODE_PATTERN 3'h2

`endif

// >>> fts_far_end.sv
// far-end model: writer and reader logic facing the fifo
`timescale 1ns/1ns
module fts_far_end #(
	parameter int              WIDTH = 18,
	parameter logic [WIDTH-1:0] BASE = 18'h0A5C3
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// commands from the bench
	input  wire logic              doWrite,
	input  wire logic              doRead,
	// fifo side
	output logic                   wrEnN,
	output logic [WIDTH-1:0]       wrData,
	output logic                   rdEnN
);
	logic [WIDTH-1:0] cnt_q;
	logic [WIDTH-1:0] cnt_d;

	// ================================================================
	// writer: one new word per enabled edge
	always_comb begin
		cnt_d = doWrite ? cnt_q + 1'b1 : cnt_q;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= BASE;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// idle data lines show the inverse so stale words never match
	assign wrEnN  = ~doWrite;
	assign wrData = doWrite ? cnt_q : ~cnt_q;
	// reader: low enable sampled on the rising edge
	assign rdEnN  = ~doRead;
endmodule

// >>> fts_fifo.sv
// storage fifo with valid/ready on both sides
`timescale 1ns/1ns
module fts_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       clear,
	// fill side
	input  wire logic                       wrValid,
	output logic                            wrReady,
	input  wire logic [WIDTH-1:0]           wrData,
	// drain side
	output logic                            rdValid,
	input  wire logic                       rdReady,
	output logic [WIDTH-1:0]                rdData,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic             push, pop;

	// ptr advance with wrap for any depth
	function automatic logic [PW-1:0] nextPtr(input logic [PW-1:0] p);
		nextPtr = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction

	// ================================================================
	// handshake and next state
	always_comb begin
		wrReady = (cnt_q != CW'(DEPTH));
		rdValid = (cnt_q != '0);
		push    = wrValid && wrReady;
		pop     = rdReady && rdValid; // empty pop refused [R09]
		wrPtr_d = push ? nextPtr(wrPtr_q) : wrPtr_q;
		rdPtr_d = pop ? nextPtr(rdPtr_q) : rdPtr_q;
		cnt_d   = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
		if (clear) begin
			wrPtr_d = '0;
			rdPtr_d = '0;
			cnt_d   = '0;
		end
	end

	assign rdData = mem[rdPtr_q];
	assign level  = cnt_q;

	// ================================================================
	// pointer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q   <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q   <= cnt_d;
		end
	end

	// storage array, no reset
	always_ff @(posedge clk) begin
		if (push && !clear) begin
			mem[wrPtr_q] <= wrData;
		end
	end

endmodule

// >>> fts_pkg.sv
// types shared by the fall-through timing mode selector
package fts_pkg;

	// ================================================================
	// timing mode latched at master reset
	typedef enum logic {
		FTS_STD  = 1'b0,
		FTS_FALL_THROUGH_MODE = 1'b1
	} fts_mode_t;

	// ================================================================
	// output stage states in fall-through mode
	typedef enum logic [1:0] {
		FTS_IDLE  = 2'b00,
		FTS_WAIT  = 2'b01,
		FTS_READY = 2'b10
	} fts_fall_t;

	// ================================================================
	// mode select pins, all active low
	typedef struct packed {
		logic firstLoadSelectN;
		logic readExpansionInputN;
		logic writeExpansionInputN;
	} fts_cfg_t;

	// ================================================================
	// status indicators, all active low
	typedef struct packed {
		logic emptyIndicatorN;
		logic outputReadyN;
		logic fullIndicatorN;
		logic inputReadyN;
	} fts_flags_t;

endpackage

// >>> fts_top.sv
// fifo with standard or fall-through timing chosen at master reset
`timescale 1ns/1ns
`include "fts_defines.svh"
module fts_top #(
	parameter int WIDTH = `FTS_DATA_WIDTH,
	parameter int DEPTH = `FTS_MEM_DEPTH
) (
	// clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 arst_n,
	// master reset and mode pins
	input  wire logic                 masterResetN,
	input  wire fts_pkg::fts_cfg_t    modePins,
	// write port
	input  wire logic                 wrEnN,
	input  wire logic [WIDTH-1:0]     wrData,
	// read port
	input  wire logic                 rdEnN,
	output logic [WIDTH-1:0]          rdData,
	// status
	output fts_pkg::fts_flags_t       flags,
	output fts_pkg::fts_mode_t        fallThroughMode
);
	import fts_pkg::*;

	localparam int CW = $clog2(DEPTH+1);

	fts_mode_t        mode_q, mode_d;
	fts_fall_t        fall_q, fall_d;
	logic [1:0]       edgeCnt_q, edgeCnt_d;
	logic [WIDTH-1:0] dataOut_q, dataOut_d;

	logic             fifoWrReady, fifoValid, fifoPop, fifoPush;
	logic [WIDTH-1:0] fifoData;
	logic [CW-1:0]    fifoLevel;
	logic             clearAll, outValid, avail, isFull, isFwft;
	logic [CW:0]      held;

	// pin pattern to timing mode
	function automatic fts_mode_t decodeMode(input fts_cfg_t p);
		decodeMode = (p == 3'(`FTS_FALL_THROUGH_MODE_PATTERN)) ? FTS_FALL_THROUGH_MODE : FTS_STD;
	endfunction

	// ================================================================
	// storage fifo
	assign clearAll = !masterResetN;
	assign fifoPush = !wrEnN && fifoWrReady && masterResetN;

	fts_fifo #(
		.WIDTH (WIDTH),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk     (sys_clk),
		.rst_n   (arst_n),
		.clear   (clearAll),
		.wrValid (!wrEnN && masterResetN),
		.wrReady (fifoWrReady),
		.wrData  (wrData),
		.rdValid (fifoValid),
		.rdReady (fifoPop),
		.rdData  (fifoData),
		.level   (fifoLevel)
	);

	// ================================================================
	// mode latch
	always_comb begin
		mode_d = mode_q; // held outside master reset [R10]
		if (!masterResetN) begin
			mode_d = decodeMode(modePins); // sampled during reset [R01]
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= FTS_STD;
		end else begin
			mode_q <= mode_d;
		end
	end

	assign isFwft = (mode_q == FTS_FALL_THROUGH_MODE);

	// ================================================================
	// output stage: explicit reads or fall-through
	always_comb begin
		fall_d    = fall_q;
		edgeCnt_d = edgeCnt_q;
		fifoPop   = 1'b0;
		if (!isFwft) begin
			fifoPop = !rdEnN && fifoValid; // read edge moves a word [R02] [R03] [R09]
		end else begin
			case (fall_q)
				FTS_IDLE: begin
					if (fifoValid) begin // no read enable needed [R05]
						fall_d    = FTS_WAIT;
						edgeCnt_d = 2'h1;
					end
				end
				FTS_WAIT: begin
					if (edgeCnt_q == 2'(`FTS_FALL_EDGES - 1)) begin
						fifoPop = 1'b1; // lands on third edge [R04]
						fall_d  = FTS_READY;
					end else begin
						edgeCnt_d = edgeCnt_q + 2'h1;
					end
				end
				FTS_READY: begin
					if (!rdEnN) begin
						fifoPop = fifoValid; // later words need reads [R05]
						if (!fifoValid) begin
							fall_d = FTS_IDLE;
						end
					end
				end
				default: begin
					fall_d = FTS_IDLE;
				end
			endcase
		end
		dataOut_d = fifoPop ? fifoData : dataOut_q;
		if (!masterResetN) begin
			fall_d    = FTS_IDLE;
			edgeCnt_d = 2'h0;
			fifoPop   = 1'b0;
			dataOut_d = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fall_q    <= FTS_IDLE;
			edgeCnt_q <= 2'h0;
			dataOut_q <= '0;
		end else begin
			fall_q    <= fall_d;
			edgeCnt_q <= edgeCnt_d;
			dataOut_q <= dataOut_d;
		end
	end

	// ================================================================
	// status indicators
	assign outValid = (fall_q == FTS_READY);
	assign avail    = isFwft ? outValid : fifoValid;
	// output register adds one word of room [R08]
	assign isFull   = isFwft ? (!fifoWrReady && outValid) : !fifoWrReady;
	// words held: fifo plus output register
	assign held     = (CW+1)'(fifoLevel) + (CW+1)'(outValid);

	always_comb begin
		flags.emptyIndicatorN = avail;   // high once a word is stored [R06]
		flags.outputReadyN    = !avail;  // low once first word shown [R07]
		flags.fullIndicatorN  = !isFull;
		flags.inputReadyN     = isFull;
	end

	assign rdData          = dataOut_q;
	assign fallThroughMode = mode_q;

	// ================================================================
	// checks
	a_mode_latch: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R01]
		!masterResetN |=> mode_q == decodeMode($past(modePins)))
		else $error("mode not taken from pins during master reset");

	a_mode_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
		masterResetN && $past(masterResetN) |-> $stable(mode_q))
		else $error("mode changed outside master reset");

	a_std_no_fall: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R02]
		!isFwft && rdEnN && masterResetN |=> $stable(dataOut_q))
		else $error("standard output changed without read");

	a_read_moves: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R03]
		!isFwft && !rdEnN && fifoValid && masterResetN
		|=> dataOut_q == $past(fifoData))
		else $error("read did not move stored word to output");

	a_fall_three: assert property (@(posedge sys_clk) // [R04] [R05]
		disable iff (!arst_n || !masterResetN)
		isFwft && fall_q == FTS_IDLE && !fifoValid && fifoPush
		|=> !outValid [*3] ##1 (outValid && dataOut_q == $past(wrData, 4)))
		else $error("first word not shown after three edges");

	a_empty_flag: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R06]
		!isFwft && fifoPush |=> flags.emptyIndicatorN)
		else $error("empty indicator not high after write");

	a_ready_flag: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R07]
		isFwft && outValid && !rdEnN && !fifoValid && masterResetN
		|=> flags.outputReadyN)
		else $error("output ready not released after last read");

	a_capacity: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R08]
		isFwft && flags.inputReadyN
		|-> held == (CW+1)'(DEPTH + 1))
		else $error("input ready high before depth plus one words");

	a_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R08]
		isFwft && masterResetN && !wrEnN && rdEnN && !flags.inputReadyN
		|=> held == $past(held) + 1'b1)
		else $error("write refused while input ready shown");

	a_empty_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R09]
		!isFwft && !rdEnN && !fifoValid && !fifoPush && masterResetN
		|=> $stable(dataOut_q) && $stable(fifoLevel))
		else $error("read while empty changed state");

	a_fall_through_mode_hold: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R05]
		isFwft && outValid && rdEnN && masterResetN
		|=> $stable(dataOut_q) && outValid)
		else $error("held word changed without read");

	a_fall_through_mode_reads: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R03]
		isFwft && outValid && !rdEnN && fifoValid && masterResetN
		|=> dataOut_q == $past(fifoData) && outValid)
		else $error("fall-through read did not load next word");

	a_fall_through_mode_idle_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R09]
		isFwft && fall_q == FTS_IDLE && !fifoValid && !rdEnN && masterResetN
		|=> $stable(dataOut_q) && !outValid)
		else $error("read while empty changed fall-through output");

endmodule
